/* refout_map.svh */
/*
  Register map, field positions, reset values and rate figures of the
  reference clock output selector. Assumes a 25 MHz pclk.
*/
`ifndef REFOUT_MAP_SVH
`define REFOUT_MAP_SVH

`define ADDR_W 12
`define SRC_CFG_ADDR 12'h240
`define CLK_CFG_ADDR 12'h244
`define STATUS_ADDR 12'h248

`define SRC_CFG_RESET 8'h41
`define CLK_CFG_RESET 8'h00
`define SRC_CFG_MASK 8'h7f
`define CLK_CFG_MASK 8'h3f

`define OE_BIT 6
`define TYPE_BIT 5
`define SEL_HI 4
`define SEL_LO 0
`define HOLD_BIT 5
`define BYPASS_BIT 4
`define FREE_BIT 3
`define RATE_HI 2
`define RATE_LO 0

`define ST_LOST_BIT 0
`define ST_EXT_BIT 1
`define ST_HIGH_BIT 2
`define ST_E1_BIT 3

`define RATE_SRC 3'h0
`define RATE_8K 3'h1
`define RATE_64K 3'h2
`define RATE_RSVD 3'h3
`define RATE_4M096 3'h4
`define RATE_8M192 3'h5
`define RATE_19M44 3'h6
`define RATE_32M768 3'h7

`define PCLK_HZ 25000000
`define HZ_8K 8000
`define HZ_64K 64000
`define HZ_4M096 4096000
`define HZ_8M192 8192000
`define HZ_19M44 19440000
`define HZ_32M768 32768000
`define HZ_T1 1544000
`define HZ_E1 2048000

`define NCO_W 32
`define NCO_INC(hz) (((64'(hz)) << 32) / 64'(`PCLK_HZ))

`endif

/* refout_pkg.sv */
/*
  Types of the reference clock output selector.
  Assumes refout_map.svh for all numeric figures.
*/
package refout_pkg;
  typedef enum logic [1:0] {
    MODE_SOURCE,
    MODE_SYNTH,
    MODE_HIGH
  } out_mode_t;
endpackage : refout_pkg

/* refout_nco.sv */
/*
  Phase accumulator standing in for the frequency synthesizer.
  Assumes a step per pclk cycle; output is the accumulator MSB.
*/
`timescale 1ns/1ps
module refout_nco #(
  parameter int ACC_W = 32
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Step and output
  input wire logic [ACC_W-1:0] step,
  output logic tick_clk
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;

  if (ACC_W < 8)
    $error("refout_nco: ACC_W too small");

  always_comb
  begin
    acc_nxt = acc_r;
    if (ce)
      acc_nxt = acc_r + step;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_r <= '0;
    else
      acc_r <= acc_nxt;
  end

  assign tick_clk = acc_r[ACC_W-1];
endmodule : refout_nco

/* refout_select.sv */
/*
  Reference clock output selector with APB register access.
  Assumes recovered clocks, loss flags and the external clock are
  levels synchronous to pclk; pclk also serves as master clock.
*/
// Operation
// R1 - Free-run bit matters only when the synthesizer is in the path
// R2 - Free-run 0: output locked to source at the programmed rate
// R3 - Free-run 1: free-running clock from master clock at programmed rate; rate 000 here holds the output high
// R4 - External source lost: high, or free-run clock when synthesized and free-run
// R5 - Channel lost, synthesized: high only with holdover 1 and free-run 0
// R6 - Channel lost, bypassed: holdover 0 gives T1 or E1 line rate, else high
// R7 - Rate select applies only while the synthesizer is enabled
// R8 - Locked rate 000 passes the source frequency itself
// R9 - Rate codes map to 8k, 64k, 4.096M, 8.192M, 19.44M, 32.768M
// R10 - Software never programs rate 011
// R11 - Output enable bit 6 tristates the pin at 0, resets to 1
// R12 - Input-type bit 5 marks the external clock T1 at 0, E1 at 1
// R13 - Source codes 0 to 16 pick the channel recovered clock, reset 1
// R14 - Source codes 17 and up pick the external input clock
`timescale 1ns/1ps
`include "refout_map.svh"
module refout_select #(
  parameter int NUM_CH = 17
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources
  input wire logic [NUM_CH-1:0] channel_recovered_clock,
  input wire logic [NUM_CH-1:0] channel_los,
  input wire logic external_input_clock,
  input wire logic external_los,
  input wire logic line_mode_e1,
  // Reference output pin
  output logic ref_clock_out_pin,
  output logic ref_clock_out_oe,
  // Current mode for observers
  output refout_pkg::out_mode_t out_mode
);
  import refout_pkg::*;

  if (NUM_CH < 1 || NUM_CH > 31)
    $error("refout_select: NUM_CH must leave room for the external code");

  logic [7:0] src_cfg_r;
  logic [7:0] src_cfg_nxt;
  logic [7:0] clk_cfg_r;
  logic [7:0] clk_cfg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic out_r;
  logic out_nxt;
  logic oe_r;
  logic oe_nxt;
  out_mode_t mode_r;
  out_mode_t mode_nxt;
  out_mode_t mode_sel;
  logic [`NCO_W-1:0] step_sel;
  logic [4:0] sel;
  logic is_ext;
  logic sel_clk;
  logic lost;
  logic bypass;
  logic free_run;
  logic hold_high;
  logic src_e1;
  logic [2:0] rate;
  logic nco_clk;
  logic [7:0] status;

  // Codes past the last channel fall to the external pin
  function automatic logic pick(input logic [NUM_CH-1:0] vec, input logic [4:0] code,
                                input logic ext_val);
    if (code < 5'(NUM_CH))
      pick = vec[code];
    else
      pick = ext_val;
  endfunction : pick

  function automatic logic [`NCO_W-1:0] rate_step(input logic [2:0] code);
    case (code)
      `RATE_8K: rate_step = `NCO_W'(`NCO_INC(`HZ_8K));
      `RATE_64K: rate_step = `NCO_W'(`NCO_INC(`HZ_64K));
      `RATE_4M096: rate_step = `NCO_W'(`NCO_INC(`HZ_4M096));
      `RATE_8M192: rate_step = `NCO_W'(`NCO_INC(`HZ_8M192));
      `RATE_19M44: rate_step = `NCO_W'(`NCO_INC(`HZ_19M44));
      `RATE_32M768: rate_step = `NCO_W'(`NCO_INC(`HZ_32M768));
      default: rate_step = '0;
    endcase
  endfunction : rate_step

  assign sel = src_cfg_r[`SEL_HI:`SEL_LO];
  assign is_ext = (sel >= 5'(NUM_CH));
  assign sel_clk = pick(channel_recovered_clock, sel, external_input_clock); // R13 R14
  assign lost = pick(channel_los, sel, external_los);
  assign bypass = clk_cfg_r[`BYPASS_BIT];
  assign free_run = clk_cfg_r[`FREE_BIT];
  assign hold_high = clk_cfg_r[`HOLD_BIT];
  assign rate = clk_cfg_r[`RATE_HI:`RATE_LO];
  // External rate follows its type bit; channels follow the line mode
  assign src_e1 = is_ext ? src_cfg_r[`TYPE_BIT] : line_mode_e1; // R12

  // Output path decision
  always_comb
  begin
    mode_sel = MODE_HIGH;
    step_sel = rate_step(rate); // R7 R9
    if (!lost)
    begin
      if (bypass)
        mode_sel = MODE_SOURCE; // R1
      else if (free_run)
        mode_sel = (rate == `RATE_SRC) ? MODE_HIGH : MODE_SYNTH; // R3
      else if (rate == `RATE_SRC)
        mode_sel = MODE_SOURCE; // R8
      else
        mode_sel = MODE_SYNTH; // R2
    end
    else if (is_ext)
      mode_sel = (!bypass && free_run) ? MODE_SYNTH : MODE_HIGH; // R4
    else if (!bypass)
      mode_sel = (hold_high && !free_run) ? MODE_HIGH : MODE_SYNTH; // R5
    else
    begin
      mode_sel = hold_high ? MODE_HIGH : MODE_SYNTH; // R6
      step_sel = line_mode_e1 ? `NCO_W'(`NCO_INC(`HZ_E1)) : `NCO_W'(`NCO_INC(`HZ_T1));
    end
  end

  refout_nco #(
    .ACC_W(`NCO_W)
  ) u_nco (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .step(step_sel),
    .tick_clk(nco_clk)
  );

  always_comb
  begin
    mode_nxt = mode_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    if (ce)
    begin
      mode_nxt = mode_sel;
      oe_nxt = src_cfg_r[`OE_BIT]; // R11
      case (mode_sel)
        MODE_SOURCE: out_nxt = sel_clk;
        MODE_SYNTH: out_nxt = nco_clk;
        default: out_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= MODE_HIGH;
      out_r <= 1'b1;
      oe_r <= 1'b1;
    end
    else
    begin
      mode_r <= mode_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  always_comb
  begin
    status = '0;
    status[`ST_LOST_BIT] = lost;
    status[`ST_EXT_BIT] = is_ext;
    status[`ST_HIGH_BIT] = (mode_r == MODE_HIGH);
    status[`ST_E1_BIT] = src_e1;
  end

  // APB: zero-wait answer, registered one cycle after setup
  always_comb
  begin
    src_cfg_nxt = src_cfg_r;
    clk_cfg_nxt = clk_cfg_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (ce)
    begin
      if (psel && !penable)
      begin
        pready_nxt = 1'b1;
        if (paddr == `SRC_CFG_ADDR)
          prdata_nxt = {24'h0, src_cfg_r};
        else if (paddr == `CLK_CFG_ADDR)
          prdata_nxt = {24'h0, clk_cfg_r};
        else if (paddr == `STATUS_ADDR)
          prdata_nxt = {24'h0, status};
        else
        begin
          prdata_nxt = 32'h0;
          pslverr_nxt = 1'b1;
        end
      end
      if (psel && penable && pready_r && pwrite && !pslverr_r)
      begin
        if (paddr == `SRC_CFG_ADDR)
          src_cfg_nxt = pwdata[7:0] & `SRC_CFG_MASK;
        else if (paddr == `CLK_CFG_ADDR)
          clk_cfg_nxt = pwdata[7:0] & `CLK_CFG_MASK;
      end
    end
    else
    begin
      pready_nxt = pready_r;
      pslverr_nxt = pslverr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_cfg_r <= `SRC_CFG_RESET; // R11 R12 R13
      clk_cfg_r <= `CLK_CFG_RESET;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      src_cfg_r <= src_cfg_nxt;
      clk_cfg_r <= clk_cfg_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign ref_clock_out_pin = out_r;
  assign ref_clock_out_oe = oe_r;
  assign out_mode = mode_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  bypass_pass_a: assert property ((ce && !lost && bypass) |=> (out_r == $past(sel_clk))) // R1
    else $error("bypassed source not passed to output");
  locked_rate_a: assert property ((ce && !lost && !bypass && !free_run && rate != `RATE_SRC) // R2
    |=> (out_r == $past(nco_clk) && mode_r == MODE_SYNTH))
    else $error("locked mode not on synthesizer");
  free_run_a: assert property ((ce && !lost && !bypass && free_run && rate != `RATE_SRC) // R3
    |=> (out_r == $past(nco_clk)))
    else $error("free-run mode not on synthesizer");
  ext_loss_a: assert property ((ce && lost && is_ext && !(!bypass && free_run)) // R4
    |=> (out_r && mode_r == MODE_HIGH))
    else $error("lost external source not held high");
  ch_loss_a: assert property ((ce && lost && !is_ext && !bypass && hold_high && !free_run) // R5
    |=> out_r)
    else $error("lost channel with holdover not high");
  byp_loss_rate_a: assert property ((lost && !is_ext && bypass && !hold_high) // R6
    |-> (step_sel == (line_mode_e1 ? `NCO_W'(`NCO_INC(`HZ_E1))
                                   : `NCO_W'(`NCO_INC(`HZ_T1)))))
    else $error("bypass loss fallback rate wrong");
  rate_gate_a: assert property ((!lost && bypass) |=> (mode_r != MODE_SYNTH || !$past(ce))) // R7
    else $error("rate applied while synthesizer bypassed");
  rate_pass_a: assert property ((ce && !lost && !bypass && !free_run && rate == `RATE_SRC) // R8
    |=> (out_r == $past(sel_clk)))
    else $error("rate 000 does not pass source");
  rate_map_a: assert property ((!lost && !bypass && rate == `RATE_64K) // R9
    |-> (step_sel == `NCO_W'(`NCO_INC(`HZ_64K))))
    else $error("64 kHz step wrong");
  oe_follow_a: assert property (ce |=> (ref_clock_out_oe == $past(src_cfg_r[`OE_BIT]))) // R11
    else $error("output enable does not follow bit");
  ext_type_a: assert property (is_ext |-> (status[`ST_E1_BIT] == src_cfg_r[`TYPE_BIT])) // R12
    else $error("external type bit not applied");
  src_mux_a: assert property ((sel < 5'(NUM_CH)) // R13
    |-> (sel_clk == channel_recovered_clock[sel]))
    else $error("channel clock mux wrong");
  ext_mux_a: assert property (is_ext // R14
    |-> (sel_clk == external_input_clock && lost == external_los))
    else $error("external clock mux wrong");

  ext_loss_c: cover property (lost && is_ext && free_run && !bypass);
  ch_loss_c: cover property (lost && !is_ext && bypass && !hold_high);
  apb_write_c: cover property (psel && penable && pready_r && pwrite);
  pass_c: cover property (!lost && bypass ##1 mode_r == MODE_SOURCE);
endmodule : refout_select

/* reference_clock_output_select_tb.sv */
/*
  Self-checking bench for refout_select: APB register access, source
  selection, loss fallbacks and synthesizer rates.
  Assumes refout_map.svh, refout_pkg and a 25 MHz pclk.
*/
`timescale 1ns/1ps
`include "refout_map.svh"
module reference_clock_output_select_tb;
  import refout_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic ext_clk, ext_los, e1, pin, oe, pin_q;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [16:0] ch_clk, ch_los;
  out_mode_t mode;
  logic [1:0] look;
  logic [32:0] exp_q[$];
  logic [32:0] ev;
  string nm_q[$];
  int error_cnt, comparisons, rise_n, d;
  int ks[5] = '{0, 1, 16, 17, 31};

  refout_select #(.NUM_CH(17)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_recovered_clock(ch_clk),
    .channel_los(ch_los), .external_input_clock(ext_clk),
    .external_los(ext_los), .line_mode_e1(e1), .ref_clock_out_pin(pin),
    .ref_clock_out_oe(oe), .out_mode(mode)
  );

  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic note(input string nm, input logic [32:0] v);
    nm_q.push_back(nm);
    exp_q.push_back(v);
  endtask : note

  task automatic take(input logic [32:0] seen);
    if (exp_q.size() == 0)
      chk("queue", seen, 33'h0);
    else
      chk(nm_q.pop_front(), seen, exp_q.pop_front());
  endtask : take

  // Outputs are sampled here only, so every result meets its oldest note
  always @(posedge pclk)
  begin
    if (look == 2'd3)
      rise_n = 0;
    else if (pin === 1'b1 && pin_q === 1'b0)
      rise_n++;
    pin_q = pin;
    if (psel && penable && pready === 1'b1 && !pwrite)
      take({pslverr, prdata});
    if (look == 2'd1)
      take({29'h0, oe, mode, pin});
    if (look == 2'd2)
    begin
      ev = exp_q[0];
      d = rise_n - int'(ev);
      // Start phase of the accumulator is unknown, so one edge of slack
      take((d >= -1 && d <= 1) ? ev : 33'(rise_n));
    end
  end

  task automatic apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] dat);
    bit ok;
    ok = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    psel <= 0;
    penable <= 0;
    if (!ok)
    begin
      error_cnt++;
      finish_test;
    end
  endtask : apb

  task automatic cfg(input logic [7:0] s, input logic [7:0] c);
    apb(1, `SRC_CFG_ADDR, {24'h0, s});
    apb(1, `CLK_CFG_ADDR, {24'h0, c});
  endtask : cfg

  task automatic show(input logic [7:0] s, c, input logic [16:0] chl, input logic exl,
                      input logic [3:0] v);
    cfg(s, c);
    ch_los <= chl;
    ext_los <= exl;
    repeat (3) @(posedge pclk);
    note("pin_state", {29'h0, v});
    look <= 2'd1;
    @(posedge pclk);
    look <= 2'd0;
  endtask : show

  task automatic rate(input logic [7:0] s, c, input logic l, l1, input int hz);
    cfg(s, c);
    ch_los <= {17{l}};
    ext_los <= l;
    e1 <= l1;
    repeat (4) @(posedge pclk);
    look <= 2'd3;
    @(posedge pclk);
    look <= 2'd0;
    repeat (6250) @(posedge pclk);
    note("rises", 33'(hz / 4000));
    look <= 2'd2;
    @(posedge pclk);
    look <= 2'd0;
  endtask : rate

  initial
  begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    finish_test;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, ext_clk, ext_los, e1, pin_q} = '0;
    {paddr, pwdata, ch_clk, ch_los, look, rise_n} = '0;
    ce = 1;
    seed = 32'h506fe6c9;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    note("src_cfg", 33'h41);
    apb(0, `SRC_CFG_ADDR, 0);
    note("clk_cfg", 33'h0);
    apb(0, `CLK_CFG_ADDR, 0);
    note("unmapped", {1'b1, 32'h0});
    apb(0, 12'h300, 0);
    for (int i = 0; i < 5; i++)
    begin
      seed = lfsr(seed);
      ch_clk <= seed[16:0];
      ext_clk <= seed[17];
      show(8'(32'h40 | ks[i]), 8'h10, seed[31:15] & ~(17'h1 << ks[i]), 0,
           {1'b1, MODE_SOURCE, ks[i] < 17 ? seed[ks[i]] : seed[17]});
    end
    show(8'h01, 8'h10, 0, 0, {1'b0, MODE_SOURCE, ch_clk[1]});
    // Clock enable low: a loss must not reach the output
    ce <= 0;
    ch_los <= '1;
    repeat (3) @(posedge pclk);
    note("frozen", {29'h0, 1'b0, MODE_SOURCE, ch_clk[1]});
    look <= 2'd1;
    @(posedge pclk);
    look <= 2'd0;
    ce <= 1;
    show(8'h43, 8'h00, 0, 0, {1'b1, MODE_SOURCE, ch_clk[3]});
    show(8'h43, 8'h30, '1, 1, {1'b1, MODE_HIGH, 1'b1});
    show(8'h51, 8'h10, '1, 1, {1'b1, MODE_HIGH, 1'b1});
    show(8'h51, 8'h04, '1, 1, {1'b1, MODE_HIGH, 1'b1});
    apb(1, `SRC_CFG_ADDR, 32'h71);
    note("status", 33'h0f);
    apb(0, `STATUS_ADDR, 0);
    show(8'h43, 8'h24, '1, 1, {1'b1, MODE_HIGH, 1'b1});
    rate(8'h43, 8'h01, 0, 0, `HZ_8K);
    rate(8'h43, 8'h02, 0, 0, `HZ_64K);
    rate(8'h43, 8'h04, 0, 0, `HZ_4M096);
    rate(8'h43, 8'h0d, 0, 0, `HZ_8M192);
    rate(8'h43, 8'h02, 1, 0, `HZ_64K);
    rate(8'h51, 8'h0c, 1, 0, `HZ_4M096);
    rate(8'h43, 8'h17, 1, 0, `HZ_T1);
    rate(8'h43, 8'h10, 1, 1, `HZ_E1);
    repeat (4) @(posedge pclk);
    finish_test;
  end
endmodule : reference_clock_output_select_tb
